// *** logic/cond_decode.sv ***
`timescale 1ns/1ns

//Contract
//(RULE1) A conditional jump carries a 4-bit condition; jump only when it holds.
//(RULE2) Only carry, zero, sign and overflow decide conditions; H and D never.
//(RULE3) Condition 0000 never holds; condition 1000 always holds.
//(RULE4) 0111 holds when carry is 1; 1111 holds when carry is 0.
//(RULE5) 0110 holds when zero is 1; 1110 holds when zero is 0.
//(RULE6) 1101 on sign 0, 0101 on sign 1, 0100 on overflow, 1100 otherwise.
//(RULE7) 1001 holds when sign xor overflow is 0; 0001 when it is 1.
//(RULE8) 1010 holds when zero or (sign xor overflow) is 0; 0010 when 1.
//(RULE9) 1011 holds when carry and zero are 0; 0011 when either is 1.
//(RULE10) Opcode upper nibble is row, lower nibble column; columns split 0-7, 8-F.
//(RULE11) Add with carry stores dst plus src plus carry in dst; src unchanged.
//(RULE12) Add with carry sets carry, zero, sign and signed overflow from result.
//(RULE13) Add with carry sets half carry from low nibble and clears decimal flag.
//(RULE14) General register operand spans 0-255; working register operand spans 0-15.
//(RULE15) Register pairs are even within 0-254; working pairs even within 0-14.
//(RULE16) Bit operands select a bit position 0-7.
//(RULE17) Relative offset is signed -128..+127, added to next instruction address.
//(RULE18) Short index adds signed byte offset; long index adds unsigned 16-bit offset.
//(RULE19) Direct and long immediate carry 16 bits; plain immediate is one byte.
//(RULE20) Software compares unsigned values with the unsigned conditions only.
//(RULE21) Carry, zero, sign, overflow sit in flags bits 7 to 4 at index D5h.
//(RULE22) Conditions use the latest flags with no delay visible to software.
module cond_decode
    import cond_decode_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        ce,
    input  wire logic        nrst,
    input  wire logic [11:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest
);

    // All state of the block apart from the reset synchronizer.
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic [7:0]  flags;
        logic [7:0]  opcode;
        logic [7:0]  adc_dst;
        logic [7:0]  adc_src;
        logic [3:0]  opnd_kind;
        logic [15:0] opnd_val;
        logic [15:0] opnd_base;
    } state_t;

    state_t     state_ff;
    state_t     nxt_state;
    logic [1:0] nrst_sync_ff;
    logic       nrst_sync;

    // Release of the reset passes through two flip-flops.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            nrst_sync_ff <= 2'h0;
        end else if (ce) begin
            nrst_sync_ff <= {nrst_sync_ff[0], 1'b1};
        end
    end
    assign nrst_sync = nrst_sync_ff[1];

    // Evaluate a condition field against the four testable flags.
    function automatic logic cond_holds(input logic [3:0] field, input logic c,
                                        input logic z, input logic s, input logic v);
        logic r;
        r = 1'b0;
        case (field)
            // (RULE3) Fixed conditions.
            COND_NEVER:              r = 1'b0;
            COND_ALWAYS:             r = 1'b1;
            // (RULE4) Carry conditions.
            COND_UNSIGNED_BELOW:     r = c;
            COND_UNSIGNED_NOT_BELOW: r = ~c;
            // (RULE5) Zero conditions.
            COND_OPERANDS_MATCH:     r = z;
            COND_OPERANDS_DIFFER:    r = ~z;
            // (RULE6) Sign and overflow conditions.
            COND_PLUS:               r = ~s;
            COND_MINUS:              r = s;
            COND_OVERFLOW:           r = v;
            COND_NO_OVERFLOW:        r = ~v;
            // (RULE7) Signed ordering.
            COND_SIGNED_NOT_BELOW:   r = ~(s ^ v);
            COND_SIGNED_BELOW:       r = s ^ v;
            // (RULE8) Signed ordering with equality.
            COND_SIGNED_ABOVE:       r = ~(z | (s ^ v));
            COND_SIGNED_AT_MOST:     r = z | (s ^ v);
            // (RULE9) Unsigned ordering with equality.
            COND_UNSIGNED_ABOVE:     r = ~c & ~z;
            COND_UNSIGNED_AT_MOST:   r = c | z;
            default:                 r = 1'b0;
        endcase
        return r;
    endfunction : cond_holds

    logic [9:0]  index;
    logic        req;
    logic        commit_wr;
    logic [3:0]  op_row;
    logic [3:0]  op_col;
    logic        op_group_hi;
    logic        is_cond_jump;
    logic        is_adc;
    logic [3:0]  jump_condition_field;
    logic        jump_taken;
    logic        adc_commit;
    logic [8:0]  adc_sum;
    logic [4:0]  adc_half;
    logic [7:0]  adc_flags;
    logic        opnd_ok;
    logic [15:0] opnd_ea;
    logic        sign_fits;

    // Bus request decode; one register per aligned word.
    assign index     = address[11:2];
    assign req       = read | write;
    assign commit_wr = write & state_ff.ack;

    // (RULE10) Row and column split of the opcode byte.
    assign op_row       = state_ff.opcode[7:4];
    assign op_col       = state_ff.opcode[3:0];
    assign op_group_hi  = op_col[3];
    assign is_cond_jump = op_group_hi & ((op_col == COL_JUMP_REL) | (op_col == COL_JUMP_DIR));
    assign is_adc       = (op_row == ROW_ADC) & (op_col >= COL_ADC_LO) & (op_col <= COL_ADC_HI);
    assign jump_condition_field = op_row;

    // (RULE1) Jump decision from the stored opcode and current flags.
    // (RULE2) Only carry, zero, sign and overflow reach the evaluation.
    // (RULE22) Flags are read straight from the register, no extra stage.
    assign jump_taken = is_cond_jump & cond_holds(jump_condition_field,
                                                  state_ff.flags[FLAG_C],
                                                  state_ff.flags[FLAG_Z],
                                                  state_ff.flags[FLAG_S],
                                                  state_ff.flags[FLAG_V]);

    // (RULE11) Sum of destination, source and carry.
    assign adc_commit = commit_wr & (index == IDX_ADC_GO) & byteenable[0] & writedata[0];
    assign adc_sum  = {1'b0, state_ff.adc_dst} + {1'b0, state_ff.adc_src}
                    + {8'h00, state_ff.flags[FLAG_C]};
    assign adc_half = {1'b0, state_ff.adc_dst[3:0]} + {1'b0, state_ff.adc_src[3:0]}
                    + {4'h0, state_ff.flags[FLAG_C]};

    // New flags after add with carry; the two low flags are kept.
    always_comb begin
        adc_flags = state_ff.flags;
        // (RULE12) Carry, zero, sign and overflow from the result.
        adc_flags[FLAG_C] = adc_sum[8];
        adc_flags[FLAG_Z] = (adc_sum[7:0] == 8'h00);
        adc_flags[FLAG_S] = adc_sum[7];
        adc_flags[FLAG_V] = (state_ff.adc_dst[7] == state_ff.adc_src[7])
                          & (adc_sum[7] != state_ff.adc_dst[7]);
        // (RULE13) Half carry from the low nibble, decimal flag cleared.
        adc_flags[FLAG_H] = adc_half[4];
        adc_flags[FLAG_D] = 1'b0;
    end

    // Operand range check and effective address.
    assign sign_fits = (state_ff.opnd_val[15:7] == 9'h000) | (state_ff.opnd_val[15:7] == 9'h1FF);
    always_comb begin
        opnd_ok = 1'b0;
        opnd_ea = state_ff.opnd_val;
        case (state_ff.opnd_kind)
            // (RULE14) Register and working register spans.
            OPND_GEN_REG:   opnd_ok = (state_ff.opnd_val <= LIM_BYTE);
            OPND_WORK_REG:  opnd_ok = (state_ff.opnd_val <= LIM_NIBBLE);
            // (RULE15) Even pair addresses only.
            OPND_REG_PAIR:  opnd_ok = (state_ff.opnd_val <= LIM_PAIR) & ~state_ff.opnd_val[0];
            OPND_WORK_PAIR: opnd_ok = (state_ff.opnd_val <= LIM_WPAIR) & ~state_ff.opnd_val[0];
            // (RULE16) Bit position span.
            OPND_BIT:       opnd_ok = (state_ff.opnd_val <= LIM_BIT);
            // (RULE17) Signed offset from the next instruction address.
            OPND_RELATIVE: begin
                opnd_ok = sign_fits;
                opnd_ea = state_ff.opnd_base + state_ff.opnd_val;
            end
            // (RULE18) Short index uses a signed byte offset.
            OPND_IDX_SHORT: begin
                opnd_ok = sign_fits & ~state_ff.opnd_base[0];
                opnd_ea = state_ff.opnd_base + state_ff.opnd_val;
            end
            // (RULE18) Long index uses an unsigned 16-bit offset.
            OPND_IDX_LONG: begin
                opnd_ok = ~state_ff.opnd_base[0];
                opnd_ea = state_ff.opnd_base + state_ff.opnd_val;
            end
            // (RULE19) Sixteen-bit and one-byte values.
            OPND_DIRECT:    opnd_ok = 1'b1;
            OPND_IMM_LONG:  opnd_ok = 1'b1;
            OPND_IMM:       opnd_ok = (state_ff.opnd_val <= LIM_BYTE);
            default:        opnd_ok = 1'b0;
        endcase
    end

    // Next state: bus answer, register writes and add with carry.
    always_comb begin
        nxt_state     = state_ff;
        nxt_state.ack = req & ~state_ff.ack;
        // Read data is caught in the first cycle of a read and then stands.
        if (read && !state_ff.ack) begin
            case (index)
                IDX_OPCODE:   nxt_state.rdata = {24'h000000, state_ff.opcode};
                IDX_DECODE:   nxt_state.rdata = {16'h0000, jump_condition_field, jump_taken,
                                                 is_adc, is_cond_jump, op_group_hi,
                                                 op_row, op_col};
                IDX_ADC_DST:  nxt_state.rdata = {24'h000000, state_ff.adc_dst};
                IDX_ADC_SRC:  nxt_state.rdata = {24'h000000, state_ff.adc_src};
                IDX_OPND_KND: nxt_state.rdata = {28'h0000000, state_ff.opnd_kind};
                IDX_OPND_VAL: nxt_state.rdata = {16'h0000, state_ff.opnd_val};
                IDX_OPND_BAS: nxt_state.rdata = {16'h0000, state_ff.opnd_base};
                IDX_OPND_STA: nxt_state.rdata = {15'h0000, opnd_ok, opnd_ea};
                // (RULE21) Testable flags in bits 7 to 4.
                IDX_FLAGS:    nxt_state.rdata = {24'h000000, state_ff.flags};
                default:      nxt_state.rdata = 32'h00000000;
            endcase
        end
        // Writes take effect at the edge where waitrequest is low.
        if (commit_wr) begin
            case (index)
                IDX_OPCODE: begin
                    if (byteenable[0]) begin
                        nxt_state.opcode = writedata[7:0];
                    end
                end
                IDX_ADC_DST: begin
                    if (byteenable[0]) begin
                        nxt_state.adc_dst = writedata[7:0];
                    end
                end
                IDX_ADC_SRC: begin
                    if (byteenable[0]) begin
                        nxt_state.adc_src = writedata[7:0];
                    end
                end
                IDX_ADC_GO: begin
                    // (RULE11) Result goes to the destination only.
                    if (adc_commit) begin
                        nxt_state.adc_dst = adc_sum[7:0];
                        nxt_state.flags   = adc_flags;
                    end
                end
                IDX_OPND_KND: begin
                    if (byteenable[0]) begin
                        nxt_state.opnd_kind = writedata[3:0];
                    end
                end
                IDX_OPND_VAL: begin
                    if (byteenable[0]) begin
                        nxt_state.opnd_val[7:0] = writedata[7:0];
                    end
                    if (byteenable[1]) begin
                        nxt_state.opnd_val[15:8] = writedata[15:8];
                    end
                end
                IDX_OPND_BAS: begin
                    if (byteenable[0]) begin
                        nxt_state.opnd_base[7:0] = writedata[7:0];
                    end
                    if (byteenable[1]) begin
                        nxt_state.opnd_base[15:8] = writedata[15:8];
                    end
                end
                IDX_FLAGS: begin
                    if (byteenable[0]) begin
                        nxt_state.flags = (writedata[7:0] & FLAGS_WMASK)
                                        | (state_ff.flags & ~FLAGS_WMASK);
                    end
                end
                default: begin
                    nxt_state.ack = 1'b0;
                end
            endcase
        end
    end

    // State register, frozen while the clock enable is low.
    always_ff @(posedge clock or negedge nrst_sync) begin
        if (!nrst_sync) begin
            state_ff.ack       <= 1'b0;
            state_ff.rdata     <= 32'h00000000;
            state_ff.flags     <= FLAGS_RST;
            state_ff.opcode    <= OPCODE_RST;
            state_ff.adc_dst   <= 8'h00;
            state_ff.adc_src   <= 8'h00;
            state_ff.opnd_kind <= 4'h0;
            state_ff.opnd_val  <= WORD_RST;
            state_ff.opnd_base <= WORD_RST;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    // Bus outputs: every access is answered in its second enabled cycle.
    assign readdata    = state_ff.rdata;
    assign waitrequest = ~(state_ff.ack & ce);

    default clocking dclk @(posedge clock); endclocking
    default disable iff (!nrst_sync);

    // (RULE3) Never-condition never jumps.
    chk_never_holds: assert property ( // (RULE3)
        (is_cond_jump && jump_condition_field == COND_NEVER) |-> !jump_taken)
        else $error("Never condition produced a jump.");

    // (RULE3) Always-condition always jumps.
    chk_always_holds: assert property ( // (RULE3)
        (is_cond_jump && jump_condition_field == COND_ALWAYS) |-> jump_taken)
        else $error("Always condition did not jump.");

    // (RULE4) Carry condition follows the carry flag.
    chk_carry_cond: assert property ( // (RULE4)
        (is_cond_jump && jump_condition_field == COND_UNSIGNED_BELOW)
        |-> (jump_taken == state_ff.flags[FLAG_C]))
        else $error("Carry condition disagrees with carry flag.");

    // (RULE2) Half carry and decimal flags cannot change the decision.
    chk_hd_ignored: assert property ( // (RULE2)
        ($stable(state_ff.opcode) && $stable(state_ff.flags[7:4])) |-> $stable(jump_taken))
        else $error("Jump decision moved without a testable flag change.");

    // (RULE8) Signed above excludes zero and sign mismatch.
    chk_signed_above: assert property ( // (RULE8)
        (is_cond_jump && jump_condition_field == COND_SIGNED_ABOVE && jump_taken)
        |-> (!state_ff.flags[FLAG_Z]
             && state_ff.flags[FLAG_S] == state_ff.flags[FLAG_V]))
        else $error("Signed above taken with wrong flags.");

    // (RULE11) Destination gets the sum and source is untouched.
    chk_adc_result: assert property ( // (RULE11)
        (adc_commit && ce) |=> (state_ff.adc_dst == $past(adc_sum[7:0])
                                && state_ff.adc_src == $past(state_ff.adc_src)))
        else $error("Add with carry result wrong.");

    // (RULE12) Carry and zero follow the stored result.
    chk_adc_flags: assert property ( // (RULE12)
        (adc_commit && ce) |=> (state_ff.flags[FLAG_C] == $past(adc_sum[8])
                                && state_ff.flags[FLAG_Z] == (state_ff.adc_dst == 8'h00)
                                && state_ff.flags[FLAG_S] == state_ff.adc_dst[7]))
        else $error("Add with carry flags wrong.");

    // (RULE13) Decimal flag cleared after add with carry.
    chk_adc_decimal: assert property ( // (RULE13)
        (adc_commit && ce) |=> !state_ff.flags[FLAG_D])
        else $error("Decimal flag not cleared by add with carry.");

    // (RULE15) Accepted register pairs are even and in range.
    chk_pair_even: assert property ( // (RULE15)
        (state_ff.opnd_kind == OPND_REG_PAIR && opnd_ok)
        |-> (!state_ff.opnd_val[0] && state_ff.opnd_val <= LIM_PAIR))
        else $error("Odd or out of range register pair accepted.");

    // (RULE17) Relative target is next address plus sign-extended offset.
    chk_rel_target: assert property ( // (RULE17)
        (state_ff.opnd_kind == OPND_RELATIVE && opnd_ok)
        |-> (opnd_ea == state_ff.opnd_base + {{8{state_ff.opnd_val[7]}},
                                              state_ff.opnd_val[7:0]}))
        else $error("Relative target address wrong.");

    // A held request is answered on the following enabled cycle.
    chk_bus_answer: assert property (
        (req && waitrequest && ce && !state_ff.ack) |=> (!ce || !waitrequest))
        else $error("Bus request not answered in two cycles.");

endmodule : cond_decode

// *** logic/cond_decode_pkg.sv ***
package cond_decode_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [9:0] IDX_OPCODE   = 10'h000;
    localparam logic [9:0] IDX_DECODE   = 10'h001;
    localparam logic [9:0] IDX_ADC_DST  = 10'h002;
    localparam logic [9:0] IDX_ADC_SRC  = 10'h003;
    localparam logic [9:0] IDX_ADC_GO   = 10'h004;
    localparam logic [9:0] IDX_OPND_KND = 10'h005;
    localparam logic [9:0] IDX_OPND_VAL = 10'h006;
    localparam logic [9:0] IDX_OPND_BAS = 10'h007;
    localparam logic [9:0] IDX_OPND_STA = 10'h008;
    localparam logic [9:0] IDX_FLAGS    = 10'h0D5;

    // Flag bit positions inside the flags register.
    localparam int FLAG_C   = 7;
    localparam int FLAG_Z   = 6;
    localparam int FLAG_S   = 5;
    localparam int FLAG_V   = 4;
    localparam int FLAG_D   = 3;
    localparam int FLAG_H   = 2;
    localparam int FLAG_FIS = 1;

    // Values after reset.
    localparam logic [7:0]  FLAGS_RST  = 8'h00;
    localparam logic [7:0]  OPCODE_RST = 8'hFF;
    localparam logic [15:0] WORD_RST   = 16'h0000;

    // Software may write every flag except the fast interrupt status bit.
    localparam logic [7:0]  FLAGS_WMASK = 8'hFD;

    // Opcode columns that hold conditional jumps; row and columns of add with carry.
    localparam logic [3:0] COL_JUMP_REL = 4'hB;
    localparam logic [3:0] COL_JUMP_DIR = 4'hD;
    localparam logic [3:0] ROW_ADC      = 4'h1;
    localparam logic [3:0] COL_ADC_LO   = 4'h2;
    localparam logic [3:0] COL_ADC_HI   = 4'h6;

    // Operand range limits.
    localparam logic [15:0] LIM_BYTE   = 16'h00FF;
    localparam logic [15:0] LIM_NIBBLE = 16'h000F;
    localparam logic [15:0] LIM_PAIR   = 16'h00FE;
    localparam logic [15:0] LIM_WPAIR  = 16'h000E;
    localparam logic [15:0] LIM_BIT    = 16'h0007;

    // Values of the jump condition field.
    typedef enum logic [3:0] {
        COND_NEVER             = 4'b0000,
        COND_SIGNED_BELOW      = 4'b0001,
        COND_SIGNED_AT_MOST    = 4'b0010,
        COND_UNSIGNED_AT_MOST  = 4'b0011,
        COND_OVERFLOW          = 4'b0100,
        COND_MINUS             = 4'b0101,
        COND_OPERANDS_MATCH    = 4'b0110,
        COND_UNSIGNED_BELOW    = 4'b0111,
        COND_ALWAYS            = 4'b1000,
        COND_SIGNED_NOT_BELOW  = 4'b1001,
        COND_SIGNED_ABOVE      = 4'b1010,
        COND_UNSIGNED_ABOVE    = 4'b1011,
        COND_NO_OVERFLOW       = 4'b1100,
        COND_PLUS              = 4'b1101,
        COND_OPERANDS_DIFFER   = 4'b1110,
        COND_UNSIGNED_NOT_BELOW = 4'b1111
    } jump_cond_t;

    // Operand notations that the range checker knows.
    typedef enum logic [3:0] {
        OPND_GEN_REG   = 4'b0000,
        OPND_WORK_REG  = 4'b0001,
        OPND_REG_PAIR  = 4'b0010,
        OPND_WORK_PAIR = 4'b0011,
        OPND_BIT       = 4'b0100,
        OPND_RELATIVE  = 4'b0101,
        OPND_IDX_SHORT = 4'b0110,
        OPND_IDX_LONG  = 4'b0111,
        OPND_DIRECT    = 4'b1000,
        OPND_IMM       = 4'b1001,
        OPND_IMM_LONG  = 4'b1010
    } opnd_kind_t;

endpackage : cond_decode_pkg

// *** testbench/cond_decode_test.sv ***
`timescale 1ns/1ns
module cond_decode_test
    import cond_decode_pkg::*;
;
    logic        clock = 1'b0;
    logic        ce = 1'b1;
    logic        nrst = 1'b0;
    logic [11:0] address = 12'h000;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h00000000;
    logic [3:0]  byteenable = 4'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [31:0] rd;
    int          mismatches = 0;
    int          check_count = 0;
    // Operand cases: kind, value, base, spare bits, expected valid.
    localparam logic [39:0] OPND_TBL [21] = '{40'h1000F00001, 40'h1001000000, 40'h000FF00001,
        40'h0010000000, 40'h200FE00001, 40'h200FD00000, 40'h3000E00001, 40'h3001000000,
        40'h4000700001, 40'h4000800000, 40'h5FF8001001, 40'h5007F01001, 40'h5008001000,
        40'h6FF8000101, 40'h6000500110, 40'h7FFFF00021, 40'h8FFFF00001, 40'h900FF00001,
        40'h9010000000, 40'hAFFFF00001, 40'hB000000000};
    // Add cases: destination, source, spare, carry in.
    localparam logic [23:0] ADC_TBL [5] = '{24'h100301, 24'h7F0100, 24'hFF0001, 24'h808000,
        24'h0F0001};

    cond_decode dut (
        .clock      (clock),
        .ce         (ce),
        .nrst       (nrst),
        .address    (address),
        .read       (read),
        .write      (write),
        .writedata  (writedata),
        .byteenable (byteenable),
        .readdata   (readdata),
        .waitrequest(waitrequest)
    );

    // Clock of 10 ns period.
    always #5 clock = ~clock;

    // One bus access; the request holds until waitrequest is seen low.
    task automatic access(input logic wr, input logic [9:0] idx, input logic [15:0] d,
                          input logic [3:0] be);
        @(posedge clock);
        address    <= {idx, 2'b00};
        writedata  <= {16'h0000, d};
        byteenable <= be;
        write      <= wr;
        read       <= ~wr;
        // Waitrequest and read data are taken at the rising edge; the watchdog ends a hang.
        do begin
            @(posedge clock);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        write <= 1'b0;
        read  <= 1'b0;
    endtask : access

    // Compares one value and reports a difference at once.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Condition outcome from carry, zero, sign and overflow only.
    function automatic logic cond_hold(input logic [3:0] jump_condition_field,
                                       input logic [7:0] f);
        logic c, z, s, v, r;
        {c, z, s, v} = f[7:4];
        case (jump_condition_field[2:0])
            3'h0: r = 1'b0;
            3'h1: r = s ^ v;
            3'h2: r = z | (s ^ v);
            3'h3: r = c | z;
            3'h4: r = v;
            3'h5: r = s;
            3'h6: r = z;
            default: r = c;
        endcase
        return r ^ jump_condition_field[3];
    endfunction : cond_hold

    // Expected decode word for an opcode under given flags.
    function automatic logic [31:0] dec_exp(input logic [7:0] op, input logic [7:0] f);
        logic jmp, adc;
        jmp = (op[3:0] == 4'hB) || (op[3:0] == 4'hD);
        adc = (op[7:4] == 4'h1) && (op[3:0] >= 4'h2) && (op[3:0] <= 4'h6);
        return {16'h0000, op[7:4], jmp & cond_hold(op[7:4], f), adc, jmp, op[3], op};
    endfunction : dec_exp

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    // Watchdog cuts a hung run short.
    initial begin
        repeat (50000) @(posedge clock);
        $display("unexpected at %0t: watchdog expired", $time);
        mismatches++;
        end_sim();
    end

    // Clock enable drops for one to three cycles in mid-run; accesses must stretch, not break.
    initial begin
        for (int j = 1; j <= 3; j++) begin
            repeat (200 + j) @(posedge clock);
            ce <= 1'b0;
            repeat (j) @(posedge clock);
            ce <= 1'b1;
        end
    end

    // Main sequence: reset values, conditions, decode, add with carry, operands.
    initial begin
        logic [7:0]  f, a, b, e;
        logic [8:0]  sum;
        logic [15:0] ea;
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        repeat (4) @(posedge clock);
        access(1'b0, IDX_OPCODE, 16'h0000, 4'h0); check(rd, {24'h0, OPCODE_RST});
        access(1'b0, IDX_FLAGS, 16'h0000, 4'h0); check(rd, {24'h0, FLAGS_RST});
        access(1'b0, IDX_ADC_DST, 16'h0000, 4'h0); check(rd, 32'h0);
        access(1'b0, 10'h3FF, 16'h0000, 4'h0); check(rd, 32'h0);
        access(1'b1, IDX_FLAGS, 16'hFFFF, 4'h3);
        access(1'b0, IDX_FLAGS, 16'h0000, 4'h0); check(rd, {24'h0, FLAGS_WMASK});
        access(1'b1, IDX_OPCODE, 16'h0000, 4'h0);
        access(1'b0, IDX_OPCODE, 16'h0000, 4'h0); check(rd, {24'h0, OPCODE_RST});
        for (int i = 0; i < 256; i++) begin
            f = {i[3:0], i[1] ^ i[4], i[2] ^ i[5], 2'b00};
            a = {i[7:4], i[0] ? COL_JUMP_REL : COL_JUMP_DIR};
            access(1'b1, IDX_FLAGS, {8'h00, f}, 4'h1);
            access(1'b1, IDX_OPCODE, {8'h00, a}, 4'h1);
            access(1'b0, IDX_DECODE, 16'h0000, 4'h0);
            check(rd & 32'hFFFF, dec_exp(a, f));
            check(rd & 32'hFFFF, dec_exp(a, f));
        end
        for (int i = 8'h11; i <= 8'h18; i++) begin
            access(1'b1, IDX_OPCODE, {8'h00, i[7:0]}, 4'h1);
            access(1'b0, IDX_DECODE, 16'h0000, 4'h0);
            check(rd & 32'hFFFF, dec_exp(i[7:0], f));
        end
        foreach (ADC_TBL[k]) begin
            {a, b} = ADC_TBL[k][23:8];
            sum = a + b + ADC_TBL[k][0];
            e = sum[7:0];
            access(1'b1, IDX_ADC_DST, {8'h00, a}, 4'h1);
            access(1'b1, IDX_ADC_SRC, {8'h00, b}, 4'h1);
            access(1'b1, IDX_FLAGS, {8'h00, ADC_TBL[k][0], 7'h08}, 4'h1);
            access(1'b1, IDX_ADC_GO, 16'h0001, 4'h1);
            access(1'b0, IDX_ADC_DST, 16'h0000, 4'h0); check(rd, {24'h0, e});
            access(1'b0, IDX_ADC_SRC, 16'h0000, 4'h0); check(rd, {24'h0, b});
            access(1'b0, IDX_FLAGS, 16'h0000, 4'h0);
            check(rd, {24'h0, sum[8], e == 8'h00, e[7], (a[7] == b[7]) && (e[7] != a[7]),
                1'b0, (a[3:0] + b[3:0] + ADC_TBL[k][0]) > 5'h0F, 2'b00});
        end
        foreach (OPND_TBL[k]) begin
            ea = OPND_TBL[k][35:20];
            if (OPND_TBL[k][39:36] inside {4'h5, 4'h6, 4'h7}) begin
                ea = OPND_TBL[k][35:20] + OPND_TBL[k][19:4];
            end
            access(1'b1, IDX_OPND_KND, {12'h000, OPND_TBL[k][39:36]}, 4'h1);
            access(1'b1, IDX_OPND_VAL, OPND_TBL[k][35:20], 4'h3);
            access(1'b1, IDX_OPND_BAS, OPND_TBL[k][19:4], 4'h3);
            access(1'b0, IDX_OPND_STA, 16'h0000, 4'h0);
            check(rd, {15'h0000, OPND_TBL[k][0], ea});
            check(rd, {15'h0000, OPND_TBL[k][0], ea});
        end
        end_sim();
    end
endmodule : cond_decode_test
